// file: abam_pkg.sv
// Constants and carrier types for the access bank address mapper
package abam_pkg;

  localparam int unsigned ADDR_W        = 12;
  localparam int unsigned OFS_W         = 8;
  localparam int unsigned BANK_W        = 4;
  localparam int unsigned DATA_W        = 8;
  localparam int unsigned BANK_CNT      = 16;

  localparam logic [OFS_W-1:0]  ACC_SPLIT     = 8'h80;
  localparam logic [ADDR_W-1:0] ACC_LOW_BASE  = 12'h000;
  localparam logic [ADDR_W-1:0] ACC_HIGH_BASE = 12'hF00;
  localparam logic [BANK_W-1:0] ACC_LOW_BANK  = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HIGH_BANK = 4'hF;
  localparam logic [DATA_W-1:0] BANK_SEL_RST  = 8'h00;
  localparam logic [DATA_W-1:0] RD_ZERO       = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_RST      = 12'h000;

  typedef struct packed {
    logic              acc;
    logic [OFS_W-1:0]  offset;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
  } abam_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] bank_sel;
    logic [ADDR_W-1:0] addr;
    logic              rd;
    logic              wr;
    logic [DATA_W-1:0] wdata;
    logic              pend_rd;
    logic              pend_impl;
    logic [DATA_W-1:0] rdata;
    logic              rvalid;
    logic              drop;
  } abam_state_t;

endpackage : abam_pkg

// file: abam_map.sv
// Combinational operand to data address mapping
`timescale 1ns/100ps
module abam_map
(
  // Instruction fields
  input  wire logic                           acc,
  input  wire logic [abam_pkg::OFS_W-1:0]     offset,
  // Current bank
  input  wire logic [abam_pkg::BANK_W-1:0]    bank,
  // Mapped result
  output logic      [abam_pkg::ADDR_W-1:0]    addr,
  output logic      [abam_pkg::BANK_W-1:0]    bank_used
);

  always_comb
  begin
    if (acc)
    begin
      addr = {bank, offset};
    end
    else if (offset < abam_pkg::ACC_SPLIT)
    begin
      addr = abam_pkg::ACC_LOW_BASE + {4'h0, offset};
    end
    else
    begin
      addr = abam_pkg::ACC_HIGH_BASE + {4'h0, offset};
    end
    bank_used = addr[abam_pkg::ADDR_W-1 -: abam_pkg::BANK_W];
  end

endmodule : abam_map

// file: abam_top.sv
// Data memory address mapper with bank select register and access bank
`timescale 1ns/100ps
module abam_top
#(
  parameter logic [15:0] IMPL_MASK = 16'hFFFF
)
(
  // Clock and reset
  input  wire logic                            clock,
  input  wire logic                            sys_rst,
  // Core data access request
  input  wire logic                            req_valid,
  input  wire abam_pkg::abam_req_t             req,
  // Bank register load from decoder
  input  wire logic                            bank_load_en,
  input  wire logic [abam_pkg::DATA_W-1:0]     bank_load_data,
  // Data RAM port
  output logic      [abam_pkg::ADDR_W-1:0]     ram_addr,
  output logic                                 ram_rd_en,
  output logic                                 ram_wr_en,
  output logic      [abam_pkg::DATA_W-1:0]     ram_wr_data,
  input  wire logic [abam_pkg::DATA_W-1:0]     ram_rd_data,
  // Read return and status to core
  output logic                                 rd_valid,
  output logic      [abam_pkg::DATA_W-1:0]     rd_data,
  output logic      [abam_pkg::DATA_W-1:0]     bank_select_register,
  output logic                                 access_dropped
);

  // Access bank needs both of its home banks present
  if (IMPL_MASK[0] !== 1'b1 || IMPL_MASK[15] !== 1'b1)
  begin : g_mask_check
    $error("IMPL_MASK must implement banks 0 and 15");
  end

  abam_pkg::abam_state_t st_ff;
  abam_pkg::abam_state_t nxt_st;

  logic [abam_pkg::ADDR_W-1:0] map_addr;
  logic [abam_pkg::BANK_W-1:0] map_bank;
  logic                        map_impl;

  abam_map u_map
  (
    .acc       (req.acc),
    .offset    (req.offset),
    .bank      (st_ff.bank_sel[abam_pkg::BANK_W-1:0]),
    .addr      (map_addr),
    .bank_used (map_bank)
  );

  assign map_impl = IMPL_MASK[map_bank];

  always_comb
  begin
    nxt_st         = st_ff;
    nxt_st.rd      = 1'b0;
    nxt_st.wr      = 1'b0;
    nxt_st.rvalid  = 1'b0;
    nxt_st.drop    = 1'b0;
    nxt_st.pend_rd = 1'b0;
    if (req_valid)
    begin
      nxt_st.addr      = map_addr;
      nxt_st.wdata     = req.wdata;
      // Read wins if decoder ever raises both
      nxt_st.rd        = req.rd & map_impl;
      nxt_st.wr        = req.wr & ~req.rd & map_impl;
      nxt_st.pend_rd   = req.rd;
      nxt_st.pend_impl = map_impl;
      nxt_st.drop      = ~map_impl & (req.rd | req.wr);
    end
    // RAM answers in the cycle its read enable stands
    if (st_ff.pend_rd)
    begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata  = st_ff.pend_impl ? ram_rd_data : abam_pkg::RD_ZERO;
    end
    // Load takes effect for the next request, not the one beside it
    if (bank_load_en)
    begin
      nxt_st.bank_sel = {4'h0, bank_load_data[abam_pkg::BANK_W-1:0]};
    end
  end

  always_ff @(posedge clock)
  begin
    if (sys_rst)
    begin
      st_ff.bank_sel  <= abam_pkg::BANK_SEL_RST;
      st_ff.addr      <= abam_pkg::ADDR_RST;
      st_ff.rd        <= 1'b0;
      st_ff.wr        <= 1'b0;
      st_ff.wdata     <= abam_pkg::RD_ZERO;
      st_ff.pend_rd   <= 1'b0;
      st_ff.pend_impl <= 1'b0;
      st_ff.rdata     <= abam_pkg::RD_ZERO;
      st_ff.rvalid    <= 1'b0;
      st_ff.drop      <= 1'b0;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign ram_addr             = st_ff.addr;
  assign ram_rd_en            = st_ff.rd;
  assign ram_wr_en            = st_ff.wr;
  assign ram_wr_data          = st_ff.wdata;
  assign rd_valid             = st_ff.rvalid;
  assign rd_data              = st_ff.rdata;
  assign bank_select_register = st_ff.bank_sel;
  assign access_dropped       = st_ff.drop;

  default clocking cb @(posedge clock);
  endclocking
  default disable iff (sys_rst);

  sequence s_acc_req(logic [7:0] ofs);
    req_valid && !req.acc && (req.offset == ofs);
  endsequence

  sequence s_rd_req;
    req_valid && req.rd;
  endsequence

  sequence s_unimpl_rd;
    req_valid && req.rd && !map_impl;
  endsequence

  property p_acc_low;
    req_valid && !req.acc && (req.offset < 8'h80) |=>
      ram_addr == {4'h0, $past(req.offset)};
  endproperty
  a_acc_low : assert property (p_acc_low)
    else $error("Access low region address wrong");

  property p_acc_high;
    req_valid && !req.acc && (req.offset >= 8'h80) |=>
      ram_addr == {4'hF, $past(req.offset)};
  endproperty
  a_acc_high : assert property (p_acc_high)
    else $error("Access high region address wrong");

  property p_banked;
    req_valid && req.acc |=>
      ram_addr == {$past(st_ff.bank_sel[3:0]), $past(req.offset)};
  endproperty
  a_banked : assert property (p_banked)
    else $error("Banked address does not follow bank register");

  property p_contig;
    s_acc_req(8'h7F) ##1 s_acc_req(8'h80) |=>
      (ram_addr == 12'hF80) && ($past(ram_addr) == 12'h07F);
  endproperty
  a_contig : assert property (p_contig)
    else $error("Access window not contiguous at the split");

  property p_bank_upper;
    bank_select_register[7:4] == 4'h0;
  endproperty
  a_bank_upper : assert property (p_bank_upper)
    else $error("Bank register upper nibble not zero");

  property p_bank_load;
    bank_load_en |=> bank_select_register[3:0] == $past(bank_load_data[3:0]);
  endproperty
  a_bank_load : assert property (p_bank_load)
    else $error("Bank register load lost");

  property p_unimpl_rd;
    s_unimpl_rd |=> !ram_rd_en && access_dropped ##1 rd_valid && (rd_data == 8'h00);
  endproperty
  a_unimpl_rd : assert property (p_unimpl_rd)
    else $error("Unimplemented bank read not zero");

  property p_unimpl_wr;
    req_valid && req.wr && !req.rd && !map_impl |=> !ram_wr_en && access_dropped;
  endproperty
  a_unimpl_wr : assert property (p_unimpl_wr)
    else $error("Write to unimplemented bank reached RAM");

  property p_offset;
    req_valid |=> ram_addr[7:0] == $past(req.offset);
  endproperty
  a_offset : assert property (p_offset)
    else $error("Offset not carried into address low byte");

  property p_rd_return;
    s_rd_req ##0 map_impl |=> ram_rd_en ##1
      rd_valid && (rd_data == $past(ram_rd_data));
  endproperty
  a_rd_return : assert property (p_rd_return)
    else $error("Read data not returned two cycles after request");

  property p_rd_wins;
    req_valid && req.rd && req.wr |=> !ram_wr_en;
  endproperty
  a_rd_wins : assert property (p_rd_wins)
    else $error("Write strobe raised for a read request");

  property p_idle;
    !req_valid |=> !ram_rd_en && !ram_wr_en && !access_dropped;
  endproperty
  a_idle : assert property (p_idle)
    else $error("RAM strobe or drop without a request");

  property p_no_rd_return;
    !(req_valid && req.rd) |-> ##2 !rd_valid;
  endproperty
  a_no_rd_return : assert property (p_no_rd_return)
    else $error("Read result without a read request");

endmodule : abam_top

// file: abam_ram_model.sv
// Data RAM model facing the mapper
`timescale 1ns/100ps
module abam_ram_model
(
  // Clock
  input  wire logic        clock,
  // RAM port
  input  wire logic [11:0] ram_addr,
  input  wire logic        ram_rd_en,
  input  wire logic        ram_wr_en,
  input  wire logic [7:0]  ram_wr_data,
  output logic      [7:0]  ram_rd_data
);
  logic [7:0] mem [4096];
  logic [7:0] last_ff = 8'h00;
  initial for (int i = 0; i < 4096; i++) mem[i] = i[7:0] ^ 8'h5A;
  // Idle bus shows inverted data, never a stale match
  assign ram_rd_data = ram_rd_en ? mem[ram_addr] : ~last_ff;
  always @(posedge clock)
  begin
    last_ff <= ram_rd_data;
    if (ram_wr_en) mem[ram_addr] <= ram_wr_data;
  end
endmodule : abam_ram_model

// file: tb.sv
// Self-checking bench for the access bank address mapper
`timescale 1ns/100ps
module tb;
  // Bank 14 left out to exercise dropped accesses
  localparam logic [15:0] MASK = 16'hBFFF;
  logic                clock = 1'b0;
  logic                sys_rst = 1'b1;
  logic                req_valid = 1'b0;
  abam_pkg::abam_req_t req = '0;
  logic                bank_load_en = 1'b0;
  logic [7:0]          bank_load_data = 8'h00;
  logic [11:0]         ram_addr;
  logic                ram_rd_en, ram_wr_en, rd_valid, access_dropped;
  logic [7:0]          ram_wr_data, ram_rd_data, rd_data, bank_select_register;
  logic [7:0]          shadow [4096];
  logic [3:0]          bank = 4'h0;
  int                  n_fail = 0;
  int                  checks = 0;
  always #25 clock = ~clock;
  abam_top #(.IMPL_MASK(MASK)) u_abam_top (.clock(clock), .sys_rst(sys_rst), .req_valid(req_valid),
    .req(req), .bank_load_en(bank_load_en), .bank_load_data(bank_load_data), .ram_addr(ram_addr),
    .ram_rd_en(ram_rd_en), .ram_wr_en(ram_wr_en), .ram_wr_data(ram_wr_data), .ram_rd_data(ram_rd_data),
    .rd_valid(rd_valid), .rd_data(rd_data), .bank_select_register(bank_select_register),
    .access_dropped(access_dropped));
  abam_ram_model u_abam_ram_model (.clock(clock), .ram_addr(ram_addr), .ram_rd_en(ram_rd_en),
    .ram_wr_en(ram_wr_en), .ram_wr_data(ram_wr_data), .ram_rd_data(ram_rd_data));
  function automatic logic [11:0] exp_addr(logic a, logic [7:0] o, logic [3:0] b);
    if (a) return {b, o};
    return (o < 8'h80) ? {4'h0, o} : {4'hF, o};
  endfunction : exp_addr
  task automatic chk(logic [11:0] seen, logic [11:0] exp, string what);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH t=%0t %s seen %h exp %h", $time, what, seen, exp);
    end
  endtask : chk
  task automatic ld_bank(logic [7:0] d);
    bank_load_en = 1'b1;
    bank_load_data = d;
    @(negedge clock);
    bank_load_en = 1'b0;
    bank = d[3:0];
    chk(bank_select_register, {4'h0, d[3:0]}, "bank");
  endtask : ld_bank
  // Called at a falling edge; one access at a time
  task automatic access(logic a, logic [7:0] o, logic w, logic [7:0] d);
    logic [11:0] ea;
    logic        hit;
    ea = exp_addr(a, o, bank);
    hit = MASK[ea[11:8]];
    req_valid = 1'b1;
    req = '{acc: a, offset: o, rd: !w, wr: w, wdata: d};
    @(negedge clock);
    req_valid = 1'b0;
    chk(access_dropped, !hit, "drop");
    chk(ram_wr_en, w && hit, "wr_en");
    chk(ram_rd_en, !w && hit, "rd_en");
    if (hit) chk(ram_addr, ea, "addr");
    if (w && hit)
    begin
      chk(ram_wr_data, d, "wdata");
      shadow[ea] = d;
    end
    @(negedge clock);
    chk(rd_valid, !w, "rd_valid");
    if (!w) chk(rd_data, hit ? shadow[ea] : 8'h00, "rd_data");
  endtask : access
  // Four reads on consecutive edges; a bank load rides beside the first
  task automatic burst(logic [7:0] nb);
    logic [11:0] ea [4];
    ea[0] = exp_addr(1'b1, 8'h42, bank);
    ea[1] = exp_addr(1'b0, 8'h7F, bank);
    ea[2] = exp_addr(1'b0, 8'h80, bank);
    ea[3] = exp_addr(1'b1, 8'h42, nb[3:0]);
    bank_load_en = 1'b1;
    bank_load_data = nb;
    for (int i = 0; i < 5; i++)
    begin
      req_valid = (i < 4);
      req = '{acc: (i == 0 || i == 3), offset: ea[i % 4][7:0], rd: 1'b1, wr: 1'b0, wdata: 8'h00};
      @(negedge clock);
      bank_load_en = 1'b0;
      if (i < 4) chk(ram_addr, ea[i], "burst addr");
      if (i > 0) chk(rd_valid, 1'b1, "burst rd_valid");
      if (i > 0) chk(rd_data, shadow[ea[i-1]], "burst rd_data");
    end
    bank = nb[3:0];
  endtask : burst
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    #250000;
    n_fail++;
    tally_and_finish();
  end
  initial
  begin
    logic [31:0] r;
    logic [7:0]  corner [4];
    corner = '{8'h00, 8'h7F, 8'h80, 8'hFF};
    for (int i = 0; i < 4096; i++) shadow[i] = i[7:0] ^ 8'h5A;
    r = $urandom(57592);
    repeat (20) @(negedge clock);
    sys_rst = 1'b0;
    chk(bank_select_register, 8'h00, "bank reset");
    ld_bank(8'hA5);
    for (int i = 0; i < 4; i++)
    begin
      r = $urandom;
      access(1'b0, corner[i], 1'b1, r[7:0]);
      access(1'b0, corner[i], 1'b0, 8'h00);
      access(1'b1, corner[i], 1'b0, 8'h00);
    end
    burst(8'h3C);
    // Both strobes raised: the read wins
    req_valid = 1'b1;
    req = '{acc: 1'b0, offset: 8'h10, rd: 1'b1, wr: 1'b1, wdata: 8'hEE};
    @(negedge clock);
    req_valid = 1'b0;
    chk(ram_wr_en, 1'b0, "both wr_en");
    chk(ram_rd_en, 1'b1, "both rd_en");
    chk(ram_addr, exp_addr(1'b0, 8'h10, bank), "both addr");
    @(negedge clock);
    chk(rd_valid, 1'b1, "both rd_valid");
    chk(rd_data, shadow[12'h010], "both rd_data");
    ld_bank(8'h0E);
    access(1'b1, 8'h33, 1'b1, 8'hC3);
    access(1'b1, 8'h33, 1'b0, 8'h00);
    access(1'b0, 8'h90, 1'b0, 8'h00);
    repeat (60)
    begin
      r = $urandom;
      if (r[0]) ld_bank(r[15:8]);
      access(r[1], r[23:16], r[2], r[31:24]);
    end
    // Reset in mid-run clears the bank register
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    bank = 4'h0;
    chk(bank_select_register, 8'h00, "bank mid reset");
    chk(rd_valid, 1'b0, "rd_valid mid reset");
    access(1'b1, 8'h5A, 1'b0, 8'h00);
    tally_and_finish();
  end
endmodule : tb
